// >>> verilog/wesl_logger.sv
// Wake-event enable, status and source logger with an AXI4-Lite register slave.
// Assumes frame detectors and suspend control on aclk give one-cycle event pulses,
// and pin wake inputs arrive asynchronously.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module wesl_logger #(
  parameter int PIN_COUNT = wesl_pkg::WESL_PIN_COUNT
) (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Receive MAC and filter engine event pulses
  input wire logic magic_rx,
  input wire logic bcast_rx,
  input wire logic dest_match_rx,
  input wire logic pattern_frame_rx,
  input wire logic [4:0] pattern_filter_index,
  input wire logic filter_engine_rx,
  input wire logic v4_syn_rx,
  input wire logic v6_syn_rx,
  input wire logic lpi_tx_exit,
  input wire logic lpi_rx_exit,
  input wire logic energy_eff_enable,
  // Asynchronous pin wake inputs
  input wire logic [PIN_COUNT-1:0] pin_wake,
  // Suspend control
  input wire logic suspend_state,
  input wire logic entering_suspend,
  input wire logic resume_done,
  output logic wake_request
);
  typedef enum logic [1:0] {WESL_AWAKE, WESL_ARMED, WESL_WAKING} wesl_state_e;

  wesl_state_e state_reg;
  logic [31:0] csr_reg;
  logic [31:0] src_reg;
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [PIN_COUNT-1:0] pin_level;
  logic [PIN_COUNT-1:0] pin_rise;

  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
      wesl_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(pin_wake[gi]),
        .level_out(pin_level[gi])
      );
    end
  endgenerate

  wesl_rise #(.WIDTH(PIN_COUNT)) u_rise (
    .aclk(aclk),
    .aresetn(aresetn),
    .level_in(pin_level),
    .rise_out(pin_rise)
  );

  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction : strb_mask

  // Word-aligned register select: 2'h1 control/status, 2'h2 source log, 2'h0 unmapped
  function automatic logic [1:0] reg_sel(input logic [11:0] addr);
    if (addr[11:2] == wesl_pkg::WESL_CSR_ADDR[11:2]) begin
      reg_sel = 2'h1;
    end else if (addr[11:2] == wesl_pkg::WESL_SRC_ADDR[11:2]) begin
      reg_sel = 2'h2;
    end else begin
      reg_sel = 2'h0;
    end
  endfunction : reg_sel

  // Write channel: address and data taken in either order, response after both
  logic wr_fire;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [31:0] wr_bits;
  assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  assign wr_addr = awaddr_reg;
  assign wr_data = wdata_reg;
  assign wr_bits = wr_data & strb_mask(wstrb_reg);

  // Ready stays low while a response stands: one write in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      awaddr_reg <= 12'h000;
      s_axi_awready <= 1'b0;
    end else if (wr_fire) begin
      aw_hold_reg <= 1'b0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_hold_reg && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_reg <= 1'b0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (wr_fire) begin
      w_hold_reg <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_hold_reg && !s_axi_bvalid;
    end
  end

  logic wr_csr;
  logic wr_src;
  always_comb begin
    wr_csr = 1'b0;
    wr_src = 1'b0;
    if (wr_fire && reg_sel(wr_addr) == 2'h1) begin
      wr_csr = 1'b1;
    end else if (wr_fire && reg_sel(wr_addr) == 2'h2) begin
      wr_src = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= wesl_pkg::WESL_RESP_OKAY;
    end else if (wr_fire) begin
      // Unmapped writes still answer, with an error, so the master never stalls
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_csr || wr_src) ? wesl_pkg::WESL_RESP_OKAY : wesl_pkg::WESL_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Wake sequence tracking
  logic armed;
  logic pattern_hit;
  logic magic_hit;
  logic bcast_hit;
  logic dest_hit;
  logic lpi_tx_hit;
  logic lpi_rx_hit;
  logic any_hit;
  assign armed = (state_reg == WESL_ARMED) && !entering_suspend;
  assign pattern_hit = pattern_frame_rx && csr_reg[wesl_pkg::WESL_PATTERN_EN_BIT];
  assign magic_hit = magic_rx && csr_reg[wesl_pkg::WESL_MAGIC_EN_BIT];
  assign bcast_hit = bcast_rx && csr_reg[wesl_pkg::WESL_BCAST_WAKE_EN_BIT];
  assign dest_hit = dest_match_rx && csr_reg[wesl_pkg::WESL_DEST_EN_BIT];
  assign lpi_tx_hit = lpi_tx_exit && csr_reg[wesl_pkg::WESL_LPI_TX_EN_BIT] && energy_eff_enable;
  assign lpi_rx_hit = lpi_rx_exit && csr_reg[wesl_pkg::WESL_LPI_RX_EN_BIT] && energy_eff_enable;
  // SYN and filter-engine wakes are enabled upstream; a pulse here already means a wake
  assign any_hit = pattern_hit || magic_hit || bcast_hit || dest_hit || lpi_tx_hit || lpi_rx_hit
    || filter_engine_rx || v4_syn_rx || v6_syn_rx || (|pin_rise);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= WESL_AWAKE;
    end else begin
      case (state_reg)
        WESL_AWAKE: begin
          if (suspend_state && !entering_suspend) begin
            state_reg <= WESL_ARMED;
          end
        end
        WESL_ARMED: begin
          if (any_hit && !entering_suspend) begin
            state_reg <= WESL_WAKING;
          end else if (!suspend_state) begin
            state_reg <= WESL_AWAKE;
          end
        end
        WESL_WAKING: begin
          if (resume_done) begin
            state_reg <= WESL_AWAKE;
          end
        end
        default: begin
          state_reg <= WESL_AWAKE;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_request <= 1'b0;
    end else begin
      // Dropped in the resume_done cycle so no stale request lingers
      wake_request <= (state_reg == WESL_WAKING) && !resume_done;
    end
  end

  // Control/status: flags set by MAC events whether or not suspended
  logic [31:0] csr_set;
  logic [31:0] csr_next;
  always_comb begin
    csr_set = 32'h00000000;
    csr_set[wesl_pkg::WESL_MAGIC_RX_BIT] = magic_rx;
    csr_set[wesl_pkg::WESL_BCAST_RX_BIT] = bcast_rx;
    csr_set[wesl_pkg::WESL_PATTERN_RX_BIT] = pattern_frame_rx;
    csr_next = csr_reg;
    if (wr_csr) begin
      csr_next = (csr_next & ~(wesl_pkg::WESL_CSR_RW_MASK & strb_mask(wstrb_reg)))
        | (wr_bits & wesl_pkg::WESL_CSR_RW_MASK);
      csr_next = csr_next & ~(wr_bits & wesl_pkg::WESL_CSR_WC_MASK);
    end
    if (resume_done && state_reg == WESL_WAKING) begin
      if (csr_reg[wesl_pkg::WESL_CLR_STS_OPT_BIT]) begin
        csr_next = csr_next & ~wesl_pkg::WESL_CSR_WC_MASK;
      end
      if (csr_reg[wesl_pkg::WESL_CLR_EN_OPT_BIT]) begin
        csr_next[wesl_pkg::WESL_BCAST_WAKE_EN_BIT] = 1'b0;
        csr_next[wesl_pkg::WESL_MAGIC_EN_BIT] = 1'b0;
        csr_next[wesl_pkg::WESL_PATTERN_EN_BIT] = 1'b0;
        csr_next[wesl_pkg::WESL_DEST_EN_BIT] = 1'b0;
        csr_next[wesl_pkg::WESL_LPI_RX_EN_BIT] = 1'b0;
        csr_next[wesl_pkg::WESL_LPI_TX_EN_BIT] = 1'b0;
      end
    end
    // Set applied last: a flag raised in the clearing cycle is never lost
    csr_next = csr_next | csr_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      csr_reg <= wesl_pkg::WESL_CSR_RESET;
    end else begin
      csr_reg <= csr_next;
    end
  end

  // Source log: only the events in the cycle that starts the wake are recorded
  logic [31:0] src_set;
  logic [31:0] src_next;
  always_comb begin
    src_set = 32'h00000000;
    if (armed && any_hit) begin
      src_set[wesl_pkg::WESL_PIN_LSB +: PIN_COUNT] = pin_rise;
      src_set[wesl_pkg::WESL_V6_SYN_BIT] = v6_syn_rx;
      src_set[wesl_pkg::WESL_V4_SYN_BIT] = v4_syn_rx;
      src_set[wesl_pkg::WESL_LPI_TX_BIT] = lpi_tx_hit;
      src_set[wesl_pkg::WESL_LPI_RX_BIT] = lpi_rx_hit;
      src_set[wesl_pkg::WESL_FILTER_BIT] = filter_engine_rx;
      src_set[wesl_pkg::WESL_DEST_BIT] = dest_hit;
      src_set[wesl_pkg::WESL_MAGIC_BIT] = magic_hit;
      src_set[wesl_pkg::WESL_BCAST_BIT] = bcast_hit;
      src_set[wesl_pkg::WESL_PATTERN_BIT] = pattern_hit;
      if (pattern_hit) begin
        src_set[wesl_pkg::WESL_INDEX_LSB +: wesl_pkg::WESL_INDEX_W] = pattern_filter_index;
      end
    end
    src_next = src_reg;
    if (wr_src) begin
      src_next = src_next & ~(wr_bits & wesl_pkg::WESL_SRC_MASK);
    end
    // Old index dropped first, else two filter numbers would merge
    if (src_set[wesl_pkg::WESL_PATTERN_BIT]) begin
      src_next[wesl_pkg::WESL_INDEX_LSB +: wesl_pkg::WESL_INDEX_W] = '0;
    end
    src_next = src_next | src_set;
    // Energy mask applied last so nothing slips through while disabled
    if (!energy_eff_enable) begin
      src_next[wesl_pkg::WESL_LPI_TX_BIT] = 1'b0;
      src_next[wesl_pkg::WESL_LPI_RX_BIT] = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_reg <= wesl_pkg::WESL_SRC_RESET;
    end else begin
      src_reg <= src_next;
    end
  end

  // Read channel: one cycle from address acceptance to data
  // Ready low while data stands: one read in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= wesl_pkg::WESL_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      if (reg_sel(s_axi_araddr) == 2'h1) begin
        s_axi_rdata <= csr_reg;
        s_axi_rresp <= wesl_pkg::WESL_RESP_OKAY;
      end else if (reg_sel(s_axi_araddr) == 2'h2) begin
        s_axi_rdata <= src_reg;
        s_axi_rresp <= wesl_pkg::WESL_RESP_OKAY;
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= wesl_pkg::WESL_RESP_SLVERR;
      end
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end
endmodule : wesl_logger
`default_nettype wire

// >>> verilog/wesl_pkg.sv
// Constants for the wake-event status logger: register map, field positions, reset values.
// Assumes one 40 MHz system clock and an AXI4-Lite master with 32-bit data.
package wesl_pkg;
  localparam logic [11:0] WESL_CSR_ADDR = 12'h140;
  localparam logic [11:0] WESL_SRC_ADDR = 12'h144;
  localparam logic [1:0] WESL_RESP_OKAY = 2'h0;
  localparam logic [1:0] WESL_RESP_SLVERR = 2'h2;
  // Control/status fields
  localparam int WESL_BCAST_WAKE_EN_BIT = 0;
  localparam int WESL_MAGIC_EN_BIT = 1;
  localparam int WESL_PATTERN_EN_BIT = 2;
  localparam int WESL_DEST_EN_BIT = 3;
  localparam int WESL_BCAST_RX_BIT = 4;
  localparam int WESL_MAGIC_RX_BIT = 5;
  localparam int WESL_PATTERN_RX_BIT = 6;
  localparam int WESL_CLR_EN_OPT_BIT = 16;
  localparam int WESL_CLR_STS_OPT_BIT = 17;
  localparam int WESL_LPI_RX_EN_BIT = 18;
  localparam int WESL_LPI_TX_EN_BIT = 19;
  localparam logic [31:0] WESL_CSR_RW_MASK = 32'h000F000F;
  localparam logic [31:0] WESL_CSR_WC_MASK = 32'h00000070;
  localparam logic [31:0] WESL_CSR_RESET = 32'h00000000;
  // Source log fields
  localparam int WESL_PIN_LSB = 20;
  localparam int WESL_PIN_COUNT = 12;
  localparam int WESL_V6_SYN_BIT = 16;
  localparam int WESL_V4_SYN_BIT = 15;
  localparam int WESL_LPI_TX_BIT = 14;
  localparam int WESL_LPI_RX_BIT = 13;
  localparam int WESL_FILTER_BIT = 12;
  localparam int WESL_DEST_BIT = 11;
  localparam int WESL_MAGIC_BIT = 10;
  localparam int WESL_BCAST_BIT = 9;
  localparam int WESL_PATTERN_BIT = 8;
  localparam int WESL_INDEX_LSB = 0;
  localparam int WESL_INDEX_W = 5;
  localparam logic [31:0] WESL_SRC_MASK = 32'hFFF1FF1F;
  localparam logic [31:0] WESL_SRC_RESET = 32'h00000000;
endpackage : wesl_pkg

// >>> verilog/wesl_sync.sv
// Three-stage synchroniser with agreement filter for one pin-level input.
// Assumes the input is asynchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
module wesl_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin_in,
  output logic level_out
);
  logic [2:0] stage_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage_reg <= 3'h0;
    end else begin
      stage_reg <= {stage_reg[1:0], pin_in};
    end
  end

  // First stage is never looked at; change counts when stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_out <= 1'b0;
    end else if (stage_reg[1] == stage_reg[2]) begin
      level_out <= stage_reg[2];
    end
  end
endmodule : wesl_sync
`default_nettype wire

// >>> verilog/wesl_rise.sv
// Rising-edge detector turning a same-clock level into a one-cycle pulse.
// Assumes the input is already in the aclk domain.
`timescale 1ns/1ps
`default_nettype none
module wesl_rise #(
  parameter int WIDTH = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] level_in,
  output logic [WIDTH-1:0] rise_out
);
  logic [WIDTH-1:0] last_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_reg <= '0;
    end else begin
      last_reg <= level_in;
    end
  end

  assign rise_out = level_in & ~last_reg;
endmodule : wesl_rise
`default_nettype wire

// >>> test/wesl_partner.sv
// Far-side model: receive MAC event pulses and suspend control steps.
// Assumes its tasks are called just after a rising aclk edge.
`timescale 1ns/1ps
`default_nettype none
module wesl_partner (
  input wire logic aclk,
  output logic [8:0] ev,
  output logic [4:0] idx,
  output logic suspend_state,
  output logic entering_suspend,
  output logic resume_done
);
  initial begin
    ev = 9'h000;
    idx = 5'h00;
    suspend_state = 1'b0;
    entering_suspend = 1'b0;
    resume_done = 1'b0;
  end
  // Index is inverted outside the pulse so a stale value is never trusted
  task automatic fire(input logic [8:0] e, input logic [4:0] i);
    ev <= e;
    idx <= i;
    @(posedge aclk);
    ev <= 9'h000;
    idx <= ~i;
    @(posedge aclk);
  endtask : fire
  // Two edges so the logger is armed before the next event
  task automatic sus(input logic s, input logic e);
    suspend_state <= s;
    entering_suspend <= e;
    repeat (2) @(posedge aclk);
  endtask : sus
  task automatic resume;
    resume_done <= 1'b1;
    @(posedge aclk);
    resume_done <= 1'b0;
    suspend_state <= 1'b0;
    @(posedge aclk);
  endtask : resume
endmodule : wesl_partner
`default_nettype wire

// >>> test/wesl_logger_properties.sv
// Port checks of the wake-event logger: bus answers, wake tracking, LPI masking.
// Assumes one aclk domain with synchronous active-low aresetn.
`timescale 1ns/1ps
`default_nettype none
module wesl_logger_properties #(
  parameter int PIN_COUNT = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic energy_eff_enable,
  input wire logic entering_suspend,
  input wire logic resume_done,
  input wire logic wake_request
);
  logic [11:0] raddr_reg;
  logic mapped;
  // Answer comes later, so the read address is kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raddr_reg <= 12'h000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      raddr_reg <= s_axi_araddr;
    end
  end
  assign mapped = raddr_reg[11:2] == wesl_pkg::WESL_CSR_ADDR[11:2]
    || raddr_reg[11:2] == wesl_pkg::WESL_SRC_ADDR[11:2];
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_entering_ignored: assert property (entering_suspend && !wake_request |=> !wake_request)
    else $error("wake while entering suspend");
  chk_wake_holds: assert property (wake_request && !resume_done |=> wake_request)
    else $error("wake dropped early");
  chk_wake_ends: assert property (wake_request && resume_done |=> !wake_request)
    else $error("wake kept after resume");
  chk_lpi_held_low: assert property ($rose(s_axi_rvalid) && raddr_reg == wesl_pkg::WESL_SRC_ADDR
    && !$past(energy_eff_enable) && !$past(energy_eff_enable, 2) |-> s_axi_rdata[14:13] == 2'h0)
    else $error("lpi source bits not low");
  chk_unmapped_read: assert property (s_axi_rvalid && !mapped |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("bad unmapped read");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  chk_read_gap: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready)
    else $error("read release wrong");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  chk_write_gap: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && !s_axi_awready)
    else $error("write release wrong");
endmodule : wesl_logger_properties
bind wesl_logger wesl_logger_properties #(.PIN_COUNT(PIN_COUNT)) chk (.*);
`default_nettype wire

// >>> test/wesl_logger_bench.sv
// Bench of the wake-event logger: registers, flags, source log, pins.
// Assumes the partner model gives MAC pulses and suspend steps.
`timescale 1ns/1ps
`default_nettype none
module wesl_logger_bench;
  localparam logic [11:0] CA = wesl_pkg::WESL_CSR_ADDR;
  localparam logic [11:0] SA = wesl_pkg::WESL_SRC_ADDR;
  localparam logic [31:0] ONES = 32'hFFFFFFFF;
  localparam int EVB[4] = '{1, 0, 3, 2};
  localparam int SRB[4] = '{9, 10, 8, 11};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic energy_eff_enable = 1'b0;
  logic [11:0] pin_wake = 12'h000;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wake_request;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic magic_rx, bcast_rx, dest_match_rx, pattern_frame_rx, filter_engine_rx, v4_syn_rx, v6_syn_rx;
  wire logic lpi_tx_exit, lpi_rx_exit, suspend_state, entering_suspend, resume_done;
  wire logic [4:0] pattern_filter_index;
  int errors = 0;
  int checks = 0;
  initial forever #12.5 aclk = ~aclk;
  wesl_logger dut (.s_axi_awprot(3'h0), .s_axi_arprot(3'h0), .s_axi_wstrb(4'hF), .*);
  wesl_partner mac (.aclk, .ev({lpi_rx_exit, lpi_tx_exit, v6_syn_rx, v4_syn_rx, filter_engine_rx, pattern_frame_rx,
    dest_match_rx, bcast_rx, magic_rx}), .idx(pattern_filter_index), .suspend_state, .entering_suspend, .resume_done);
  task automatic wrap_up;
    if (errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic hang;
    errors++;
    $display("[ERR] %0t no answer in time", $time);
    wrap_up();
  endtask : hang
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] er;
    er = (a == CA || a == SA) ? wesl_pkg::WESL_RESP_OKAY : wesl_pkg::WESL_RESP_SLVERR;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    repeat (40) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        cmp({30'h0, s_axi_bresp}, {30'h0, er});
        s_axi_bready <= 1'b0;
        @(posedge aclk);
        return;
      end
    end
    hang();
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [1:0] er;
    er = (a == CA || a == SA) ? wesl_pkg::WESL_RESP_OKAY : wesl_pkg::WESL_RESP_SLVERR;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    repeat (40) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        cmp(s_axi_rdata, e);
        cmp({30'h0, s_axi_rresp}, {30'h0, er});
        s_axi_rready <= 1'b0;
        @(posedge aclk);
        return;
      end
    end
    hang();
  endtask : rd
  task automatic t_regs;
    rd(CA, wesl_pkg::WESL_CSR_RESET);
    rd(SA, wesl_pkg::WESL_SRC_RESET);
    wr(CA, ONES);
    rd(CA, wesl_pkg::WESL_CSR_RW_MASK);
    wr(SA, ONES);
    rd(SA, 32'h0);
    wr(12'h148, ONES);
    rd(12'h148, 32'h0);
  endtask : t_regs
  task automatic t_flags;
    wr(CA, 32'h0);
    mac.fire(9'h001, 5'h00);
    rd(CA, 32'h20);
    mac.fire(9'h00A, 5'h00);
    rd(CA, 32'h70);
    wr(CA, 32'h20);
    rd(CA, 32'h50);
    // Pulse lands on the edge where the clear is applied
    fork
      wr(CA, 32'h10);
      begin
        @(posedge aclk);
        mac.fire(9'h002, 5'h00);
      end
    join
    rd(CA, 32'h50);
    wr(CA, 32'h50);
    rd(CA, 32'h0);
  endtask : t_flags
  task automatic t_multi;
    wr(CA, 32'hF);
    mac.sus(1'b1, 1'b0);
    mac.fire(9'h03F, 5'h15);
    mac.fire(9'h040, 5'h00);
    cmp({31'h0, wake_request}, 32'h1);
    rd(SA, 32'h00009F15);
    mac.resume();
    rd(SA, 32'h00009F15);
    wr(SA, ONES);
    rd(SA, 32'h0);
  endtask : t_multi
  task automatic t_gate;
    logic [8:0] own;
    for (int i = 0; i < 4; i++) begin
      own = 9'h001 << EVB[i];
      wr(CA, 32'h1 << i);
      mac.sus(1'b1, 1'b0);
      mac.fire(9'h00F & ~own, 5'h0A);
      cmp({31'h0, wake_request}, 32'h0);
      mac.fire(own, 5'h0A);
      rd(SA, (32'h1 << SRB[i]) | (i == 2 ? 32'hA : 32'h0));
      mac.resume();
      wr(SA, ONES);
    end
  endtask : t_gate
  task automatic t_resume;
    wr(CA, 32'h0003000F);
    mac.sus(1'b1, 1'b1);
    mac.fire(9'h00F, 5'h01);
    mac.sus(1'b1, 1'b0);
    rd(SA, 32'h0);
    mac.fire(9'h001, 5'h00);
    mac.resume();
    rd(CA, 32'h00030000);
    rd(SA, 32'h400);
    wr(SA, ONES);
  endtask : t_resume
  task automatic t_lpi;
    for (int j = 0; j < 2; j++) begin
      wr(CA, 32'h1 << (18 + j));
      energy_eff_enable <= 1'b1;
      mac.sus(1'b1, 1'b0);
      mac.fire(9'h180, 5'h00);
      rd(SA, 32'h1 << (13 + j));
      energy_eff_enable <= 1'b0;
      @(posedge aclk);
      rd(SA, 32'h0);
      mac.resume();
      wr(SA, ONES);
    end
  endtask : t_lpi
  task automatic t_pins;
    int n;
    wr(CA, 32'h0);
    for (int p = 0; p < 12; p++) begin
      mac.sus(1'b1, 1'b0);
      pin_wake <= 12'h001 << p;
      for (n = 0; n < 20 && wake_request !== 1'b1; n++) @(posedge aclk);
      if (wake_request !== 1'b1) hang();
      pin_wake <= ~(12'h001 << p);
      repeat (8) @(posedge aclk);
      rd(SA, 32'h1 << (20 + p));
      pin_wake <= 12'h000;
      mac.resume();
      wr(SA, ONES);
    end
  endtask : t_pins
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_flags();
    t_multi();
    t_gate();
    t_resume();
    t_lpi();
    t_pins();
    wrap_up();
  end
endmodule : wesl_logger_bench
`default_nettype wire
